// >>> rtl/uwk_pkg.sv
// Package of constants and types for the serial receiver with wakeup
package uwk_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // Control word
    localparam logic [7:0] OFS_STATUS = 8'h04;  // Receiver status flags
    localparam logic [7:0] OFS_DATA   = 8'h08;  // Received character
    // Control field positions
    localparam int CTL_ENABLE = 0;              // Receiver enable
    localparam int CTL_STBY   = 1;              // rx_standby_bit
    localparam int CTL_WAKE   = 2;              // Wake method, 1 = address mark
    localparam int CTL_ILT    = 3;              // idle_count_start_bit
    localparam int CTL_NINE   = 4;              // Nine-bit characters
    // Status field positions
    localparam int STS_FULL   = 0;              // rx_data_full_flag
    localparam int STS_FRAME  = 1;              // frame_error_flag
    localparam int STS_NOISE  = 2;              // noise_flag
    localparam int STS_IDLE   = 3;              // Idle line seen
    localparam int STS_ACTIVE = 4;              // Frame in progress
    // Sample tick positions inside one bit period
    localparam logic [4:0] TK_FIRST = 5'h01;    // Tick of the falling edge
    localparam logic [4:0] TK_Q1    = 5'h03;    // First start check
    localparam logic [4:0] TK_Q2    = 5'h05;    // Second start check
    localparam logic [4:0] TK_Q3    = 5'h07;    // Third start check
    localparam logic [4:0] TK_S1    = 5'h08;    // First data sample
    localparam logic [4:0] TK_S2    = 5'h09;    // Middle data sample
    localparam logic [4:0] TK_S3    = 5'h0a;    // Last data sample
    localparam logic [4:0] TK_BIT   = 5'h10;    // Ticks per bit
    localparam logic [4:0] TK_EARLY = 5'h06;    // Latest early edge accepted
    // Data bits per frame; idle lengths include start and stop
    localparam logic [3:0] BITS_8   = 4'h8;
    localparam logic [3:0] BITS_9   = 4'h9;
    localparam logic [3:0] IDLE_8   = 4'ha;     // Idle character, 8-bit mode
    localparam logic [3:0] IDLE_9   = 4'hb;     // Idle character, 9-bit mode
    localparam logic [2:0] HIST_ALL = 3'h7;     // Three high samples
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

    // Receiver sequence states
    typedef enum logic [1:0] {ST_SEARCH, ST_START, ST_DATA, ST_STOP} uwk_rx_e;

    // Control bits written by software
    typedef struct packed {
        logic nine;
        logic idle_after_stop;
        logic wake_addr;
        logic standby;
        logic enable;
    } uwk_ctrl_s;

    // Flags read by software
    typedef struct packed {
        logic active;
        logic idle;
        logic noise;
        logic frame;
        logic full;
    } uwk_stat_s;
endpackage : uwk_pkg

// >>> rtl/uwk_rx.sv
// Serial receiver with start qualification, error flags and standby wakeup
// Overview of operation
// - Sample line at sixteen ticks per bit
// - Start edge is low after three highs
// - Start checked at ticks 3,5,7; one high noisy
// - Data bit is majority of ticks 8-10
// - Failed start restarts search, no noise flag
// - Single high at 3, 5 or 7 accepted, noisy
// - After restart, edge needs three highs again
// - Start ticks 8-10 only raise noise
// - Stop majority low sets framing error
// - Break character sets framing error
// - Framing error set with data-full flag
// - Disagreeing stop samples raise noise
// - Resynchronise on falling edges within frame
// - Stop sampled at ticks 8 to 10
// - Standby loads data, keeps full flag clear
// - Wake bit selects idle or address wakeup
// - Idle line clears standby in idle mode
// - Waking idle sets no idle, full flag
// - Idle count starts after start or stop
// - Address frame wakes before stop, sets full
// - Address mode stays asleep until address frame
// - Standby on idle line may wake at once
`timescale 1ns/100ps
`default_nettype none
module uwk_rx (
    input  wire logic        clk_sys,      // System clock, 100 MHz
    input  wire logic        rst,          // Asynchronous reset, active high
    input  wire logic        hsel,         // AHB-Lite slave select
    input  wire logic [31:0] haddr,        // AHB-Lite address
    input  wire logic [1:0]  htrans,       // AHB-Lite transfer type
    input  wire logic        hwrite,       // AHB-Lite write
    input  wire logic [2:0]  hsize,        // AHB-Lite size, words only
    input  wire logic [31:0] hwdata,       // AHB-Lite write data
    input  wire logic        hready,       // AHB-Lite bus ready
    output logic      [31:0] hrdata,       // AHB-Lite read data
    output logic             hreadyout,    // AHB-Lite slave ready
    output logic      [1:0]  hresp,        // AHB-Lite response
    input  wire logic        sample_tick,  // Pulse at sixteen times the baud rate
    input  wire logic        rx_line       // Receive line, idle high
);
    // Whole module state, one register
    typedef struct packed {
        uwk_pkg::uwk_rx_e   st;       // Receiver sequence state
        logic [4:0]         tick;     // Tick number inside the bit
        logic [3:0]         bitn;     // Data bit index
        logic [2:0]         hist;     // Recent line samples, newest at bit 0
        logic [2:0]         smp;      // Qualification or data samples
        logic               last_one; // Previous determined bit was high
        logic               nacc;     // Noise seen in this frame
        logic [8:0]         shreg;    // Shift register, lsb first
        logic [8:0]         rdata;    // Received data register
        logic [7:0]         idle_cnt; // High ticks counted toward idle
        logic               armed;    // A frame arrived since last idle flag
        uwk_pkg::uwk_ctrl_s ctrl;     // Software control
        uwk_pkg::uwk_stat_s stat;     // Status flags
        logic               wr_pend;  // Write data phase pending
        logic [7:0]         wr_ofs;   // Offset of pending write
        logic [31:0]        rd;       // Read data for the data phase
    } uwk_state_s;

    uwk_state_s s_q;    // Registered state
    uwk_state_s s_d;    // Next state

    // Majority vote of three samples
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    // Three samples that do not all agree
    function automatic logic split3(input logic [2:0] v);
        split3 = (v != 3'h0) && (v != 3'h7);
    endfunction : split3

    logic        addr_ok;   // Address phase for this slave
    logic [7:0]  ofs;       // Low address bits
    logic [4:0]  idle_len;  // Idle length in bits
    logic [7:0]  idle_tks;  // Idle length in ticks
    logic        idle_hit;  // Line has been high for a whole character
    logic        frame_end; // Stop bit decided this cycle
    logic [2:0]  win;       // Samples including the present one

    assign addr_ok   = hsel && hready && (htrans == uwk_pkg::HTRANS_NONSEQ);
    assign ofs       = haddr[7:0];
    assign hrdata    = s_q.rd;
    assign hreadyout = 1'b1;                    // No wait states
    assign hresp     = uwk_pkg::HRESP_OKAY;
    assign idle_len  = {1'b0, s_q.ctrl.nine ? uwk_pkg::IDLE_9 : uwk_pkg::IDLE_8};
    assign idle_tks  = {idle_len[3:0], 4'h0};   // Bits times sixteen
    assign idle_hit  = (s_q.idle_cnt >= idle_tks);

    // Next-state logic for receiver, flags and bus
    always_comb begin
        s_d       = s_q;
        frame_end = 1'b0;
        win       = {s_q.smp[1:0], rx_line};

        // Receiver runs only on sample ticks
        if (sample_tick && s_q.ctrl.enable) begin
            s_d.hist = {s_q.hist[1:0], rx_line};
            s_d.tick = s_q.tick + 5'h01;
            unique case (s_q.st)
                uwk_pkg::ST_SEARCH: begin
                    // Low after three highs marks a start edge
                    if (!rx_line && (s_q.hist == uwk_pkg::HIST_ALL)) begin
                        s_d.st   = uwk_pkg::ST_START;
                        s_d.tick = uwk_pkg::TK_FIRST;
                        s_d.nacc = 1'b0;
                        s_d.smp  = 3'h0;
                    end
                end
                uwk_pkg::ST_START: begin
                    // Collect the three qualification samples
                    if (s_q.tick + 5'h01 == uwk_pkg::TK_Q1 ||
                        s_q.tick + 5'h01 == uwk_pkg::TK_Q2) begin
                        s_d.smp = win;
                    end
                    if (s_q.tick + 5'h01 == uwk_pkg::TK_Q3) begin
                        if (maj3(win)) begin
                            // Failed start: back to search, no noise
                            s_d.st   = uwk_pkg::ST_SEARCH;
                            s_d.tick = 5'h00;
                            s_d.hist = 3'h0;       // Three highs needed again
                        end else begin
                            // One high sample accepted but noisy
                            s_d.nacc = (win != 3'h0);
                            s_d.smp  = 3'h0;
                        end
                    end
                    // Ticks 8-10 of the start bit only flag noise
                    if (s_q.tick + 5'h01 >= uwk_pkg::TK_S1 &&
                        s_q.tick + 5'h01 <= uwk_pkg::TK_S3) begin
                        s_d.smp = win;
                    end
                    if (s_q.tick + 5'h01 == uwk_pkg::TK_S3 && maj3(win)) begin
                        s_d.nacc = 1'b1;
                    end
                    if (s_q.tick == uwk_pkg::TK_BIT) begin
                        s_d.st       = uwk_pkg::ST_DATA;
                        s_d.tick     = uwk_pkg::TK_FIRST;
                        s_d.bitn     = 4'h0;
                        s_d.last_one = 1'b0;
                    end
                end
                uwk_pkg::ST_DATA, uwk_pkg::ST_STOP: begin
                    // Samples at ticks 8, 9, 10
                    if (s_q.tick + 5'h01 >= uwk_pkg::TK_S1 &&
                        s_q.tick + 5'h01 <= uwk_pkg::TK_S3) begin
                        s_d.smp = win;
                    end
                    if (s_q.tick + 5'h01 == uwk_pkg::TK_S3) begin
                        if (split3(win)) begin
                            s_d.nacc = 1'b1;
                        end
                        if (s_q.st == uwk_pkg::ST_DATA) begin
                            s_d.last_one = maj3(win);
                            if (s_q.ctrl.nine) begin
                                s_d.shreg = {maj3(win), s_q.shreg[8:1]};
                            end else begin
                                s_d.shreg = {1'b0, maj3(win), s_q.shreg[7:1]};
                            end
                            // Only an address frame wakes, before its stop
                            if (s_q.ctrl.wake_addr && maj3(win) &&
                                s_q.bitn + 4'h1 == (s_q.ctrl.nine ? uwk_pkg::BITS_9
                                                                  : uwk_pkg::BITS_8)) begin
                                s_d.ctrl.standby = 1'b0;
                            end
                        end else begin
                            frame_end = 1'b1;
                            s_d.st    = uwk_pkg::ST_SEARCH;
                            s_d.hist  = 3'h0;
                        end
                    end
                    // Falling edge after a high bit realigns ticks
                    if (s_q.st == uwk_pkg::ST_DATA && s_q.last_one && !rx_line &&
                        s_q.hist[0] && (s_q.tick > uwk_pkg::TK_S3 ||
                                        s_q.tick < uwk_pkg::TK_EARLY)) begin
                        s_d.tick     = uwk_pkg::TK_FIRST;
                        s_d.last_one = 1'b0;
                        if (s_q.tick > uwk_pkg::TK_S3) begin
                            s_d.bitn = s_q.bitn + 4'h1;
                        end
                    end else if (s_q.tick == uwk_pkg::TK_BIT) begin
                        // Normal step to the next bit
                        s_d.tick = uwk_pkg::TK_FIRST;
                        s_d.bitn = s_q.bitn + 4'h1;
                    end
                    if (s_q.st == uwk_pkg::ST_DATA && s_d.bitn ==
                        (s_q.ctrl.nine ? uwk_pkg::BITS_9 : uwk_pkg::BITS_8)) begin
                        s_d.st = uwk_pkg::ST_STOP;
                    end
                end
            endcase

            // Idle counting: any low restarts it; may wait for stop
            if (!rx_line || (s_q.ctrl.idle_after_stop && s_q.st != uwk_pkg::ST_SEARCH)) begin
                s_d.idle_cnt = 8'h00;
            end else if (!idle_hit) begin
                s_d.idle_cnt = s_q.idle_cnt + 8'h01;
            end
        end

        // Bus address phase: capture read data, note writes
        s_d.wr_pend = 1'b0;
        if (addr_ok) begin
            s_d.wr_pend = hwrite;
            s_d.wr_ofs  = ofs;
            unique case (ofs)
                uwk_pkg::OFS_CTRL:   s_d.rd = {27'h0, s_q.ctrl};
                uwk_pkg::OFS_STATUS: s_d.rd = {27'h0, s_q.stat};
                uwk_pkg::OFS_DATA:   s_d.rd = {23'h0, s_q.rdata};
                default:             s_d.rd = 32'h0;      // Unmapped reads zero
            endcase
            // Reading data clears the flags; events below still win
            if (!hwrite && ofs == uwk_pkg::OFS_DATA) begin
                s_d.stat.full  = 1'b0;
                s_d.stat.frame = 1'b0;
                s_d.stat.noise = 1'b0;
                s_d.stat.idle  = 1'b0;
            end
        end
        // Control write in the data phase; software wins over wakeup
        if (s_q.wr_pend && s_q.wr_ofs == uwk_pkg::OFS_CTRL) begin
            s_d.ctrl = hwdata[4:0];
        end else if (s_q.ctrl.standby && !s_q.ctrl.wake_addr && idle_hit) begin
            // Idle line wakes, even if it was idle before standby
            s_d.ctrl.standby = 1'b0;
            s_d.armed        = 1'b0;                // Waking idle raises no idle flag
        end

        // Frame complete: data always loaded, flags only when awake
        if (frame_end) begin
            s_d.rdata = s_d.shreg;                     // Break leaves all zeros
            if (!s_d.ctrl.standby) begin
                s_d.stat.full  = 1'b1;
                s_d.stat.frame = !maj3(win);           // Same cycle as full
                s_d.stat.noise = s_q.nacc || split3(win);
                s_d.armed      = 1'b1;
            end
        end
        // Idle flag once per received frame; not on a waking idle
        if (sample_tick && idle_hit && s_q.armed && !s_q.ctrl.standby &&
            s_q.idle_cnt == idle_tks) begin
            s_d.stat.idle = 1'b1;
            s_d.armed     = 1'b0;
        end
        s_d.stat.active = (s_d.st != uwk_pkg::ST_SEARCH);
        if (!s_d.ctrl.enable) begin
            s_d.st = uwk_pkg::ST_SEARCH;
        end
    end

    // State register with asynchronous reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q    <= '0;
            s_q.st <= uwk_pkg::ST_SEARCH;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : uwk_rx
`default_nettype wire

// >>> sim/uwk_rx_monitor.sv
// Checker of bus-side relations of the serial receiver
`timescale 1ns/100ps
`default_nettype none
module uwk_rx_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic [1:0]  hresp,
    input wire logic        sample_tick,
    input wire logic        rx_line
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Accepted address phase, then a read of one offset
    sequence s_take;
        hsel && hready && htrans == uwk_pkg::HTRANS_NONSEQ;
    endsequence
    sequence s_read(logic [7:0] ofs);
        s_take ##0 (!hwrite && haddr[7:0] == ofs);
    endsequence
    a_ready_high: assert property (hreadyout) else $error("slave not ready");
    a_resp_okay: assert property (hresp == uwk_pkg::HRESP_OKAY) else $error("bad response");
    // Reset must hold read data at zero, so no disable here
    a_reset_zero: assert property (disable iff (1'b0) rst |-> hrdata == 32'h0)
        else $error("read data not cleared in reset");
    a_rdata_holds: assert property (!(hsel && hready && htrans == uwk_pkg::HTRANS_NONSEQ)
        |=> $stable(hrdata)) else $error("read data moved without a transfer");
    a_unmapped_zero: assert property (s_read(8'h0c) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_width: assert property (s_read(uwk_pkg::OFS_STATUS) |=> hrdata[31:5] == 27'h0)
        else $error("status upper bits set");
    a_frame_with_full: assert property (s_read(uwk_pkg::OFS_STATUS) |=>
        (!hrdata[uwk_pkg::STS_FRAME] || hrdata[uwk_pkg::STS_FULL]))
        else $error("frame error without data full");
    a_data_width: assert property (s_read(uwk_pkg::OFS_DATA) |=> hrdata[31:9] == 23'h0)
        else $error("data upper bits set");
endmodule : uwk_rx_monitor
bind uwk_rx uwk_rx_monitor uwk_rx_monitor_i (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_tick(sample_tick), .rx_line(rx_line));
`default_nettype wire

// >>> sim/uwk_tx_model.sv
// Remote transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module uwk_tx_model (
    input  wire logic clk_sys,      // System clock
    input  wire logic sample_tick,  // Sixteen ticks per nominal bit
    output var logic  rx_line       // Line into the receiver
);
    initial rx_line = 1'b1;  // Idle line is high
    // Puts one value on the line for exactly one tick
    task automatic hold(input logic v);
        rx_line <= v;
        do @(posedge clk_sys); while (sample_tick !== 1'b1);
    endtask : hold
    // Idle line between messages, as wakeup by idle expects
    task automatic idle(input int n);
        repeat (n) hold(1'b1);
    endtask : idle
    // Frame lsb first; nz flips chosen ticks of bit nzb, bt ticks per bit
    task automatic send(input logic [8:0] d, input logic nine, input logic stop,
                        input int bt, input int nzb, input logic [15:0] nz);
        logic [10:0] f;
        int          n;
        f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        n = nine ? 11 : 10;
        do @(posedge clk_sys); while (sample_tick !== 1'b1);
        idle(4);  // Three highs needed before any start edge
        for (int b = 0; b < n; b++) begin
            for (int t = 0; t < bt; t++) begin
                hold(f[b] ^ (b == nzb && t < 16 && nz[t]));
            end
        end
        rx_line <= 1'b1;
    endtask : send
endmodule : uwk_tx_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the serial receiver with wakeup
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_sys, rst, hsel, hwrite, hreadyout, sample_tick;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, hresp;
    wire logic   rx_line;       // Driven by the transmitter model
    logic        rd_phase;      // Read data phase under way
    logic [63:0] exp_q[$];      // Expected value and mask, oldest first
    logic [63:0] e;             // Note taken off the queue
    int          mismatches, check_count, cycles, seed;
    logic [7:0]  rnd;           // Random payload
    logic [15:0] nz_start [4] = '{16'h0004, 16'h0010, 16'h0040, 16'h0180};
    logic [15:0] nz_stop [3] = '{16'h0100, 16'h0080, 16'h0200};
    logic [2:0]  st_stop [3] = '{3'b101, 3'b101, 3'b101};
    // Word size only, so hsize is the one tied input
    uwk_rx uwk_rx_i (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sample_tick(sample_tick), .rx_line(rx_line));
    uwk_tx_model uwk_tx_model_i (.clk_sys(clk_sys), .sample_tick(sample_tick), .rx_line(rx_line));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Tick every other cycle keeps frames short; hang guard
    always @(posedge clk_sys) begin
        sample_tick <= ~sample_tick;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end
    // Read results compared with the oldest note
    always @(posedge clk_sys) begin
        if (rd_phase === 1'b1) begin
            e = exp_q.pop_front();
            check_count++;
            if ((hrdata & e[31:0]) !== e[63:32]) begin
                mismatches++;
                $display("mismatch at %0t: read %h want %h", $time, hrdata & e[31:0], e[63:32]);
            end
        end
    end
    // One single transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= uwk_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= ~wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({x, m});
        xfer(1'b0, a, 32'h0);
    endtask : rd
    // Status bits {noise, frame, full}, then the character, which clears them
    task automatic chk(input logic [8:0] d, input logic [2:0] s);
        rd(uwk_pkg::OFS_STATUS, {29'h0, s}, 32'h7);
        rd(uwk_pkg::OFS_DATA, {23'h0, d}, 32'h1ff);
    endtask : chk
    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        seed = 32'h4f58a72b;
        {rst, sample_tick, rd_phase} = 3'b100;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        mismatches  = 0;
        check_count = 0;
        cycles      = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(uwk_pkg::OFS_CTRL, 32'h0, 32'hffffffff);
        xfer(1'b1, uwk_pkg::OFS_CTRL, 32'h1);
        rd(8'h0c, 32'h0, 32'hffffffff);
        rnd = 8'($random(seed));
        uwk_tx_model_i.send({1'b0, rnd}, 1'b0, 1'b1, 16, 0, 16'h0);
        chk({1'b0, rnd}, 3'b001);
        // Single highs at 3, 5, 7, then a high majority at 8-10
        for (int i = 0; i < 4; i++) begin
            uwk_tx_model_i.send(9'h03c, 1'b0, 1'b1, 16, 0, nz_start[i]);
            chk(9'h03c, 3'b101);
        end
        // Two highs reject the start; no new edge follows
        uwk_tx_model_i.send(9'h0ff, 1'b0, 1'b1, 16, 0, 16'h0014);
        chk(9'h03c, 3'b000);
        uwk_tx_model_i.send(9'h081, 1'b0, 1'b0, 16, 0, 16'h0);
        chk(9'h081, 3'b011);
        uwk_tx_model_i.send(9'h000, 1'b0, 1'b0, 16, 0, 16'h0);
        chk(9'h000, 3'b011);
        for (int i = 0; i < 3; i++) begin
            uwk_tx_model_i.send(9'h066, 1'b0, 1'b1, 16, 9, nz_stop[i]);
            chk(9'h066, st_stop[i]);
        end
        xfer(1'b1, uwk_pkg::OFS_CTRL, 32'h11);
        uwk_tx_model_i.send(9'h1a5, 1'b1, 1'b1, 16, 0, 16'h0);
        chk(9'h1a5, 3'b001);
        xfer(1'b1, uwk_pkg::OFS_CTRL, 32'h1);
        // Slow sender, one extra tick per bit
        uwk_tx_model_i.send(9'h055, 1'b0, 1'b1, 17, 0, 16'h0);
        chk(9'h055, 3'b001);
        // Standby set in mid-frame, idle-line wakeup, idle counted after stop
        fork
            uwk_tx_model_i.send(9'h000, 1'b0, 1'b1, 16, 0, 16'h0);
            begin
                repeat (100) @(posedge clk_sys);
                xfer(1'b1, uwk_pkg::OFS_CTRL, 32'h0b);
            end
        join
        chk(9'h000, 3'b000);
        rd(uwk_pkg::OFS_CTRL, 32'h2, 32'h2);
        uwk_tx_model_i.idle(200);
        rd(uwk_pkg::OFS_CTRL, 32'h0, 32'h2);
        rd(uwk_pkg::OFS_STATUS, 32'h0, 32'h9);
        // Address mark wakeup: data frames keep the msb clear
        xfer(1'b1, uwk_pkg::OFS_CTRL, 32'h07);
        uwk_tx_model_i.send(9'h012, 1'b0, 1'b1, 16, 0, 16'h0);
        chk(9'h012, 3'b000);
        rd(uwk_pkg::OFS_CTRL, 32'h2, 32'h2);
        uwk_tx_model_i.send(9'h092, 1'b0, 1'b1, 16, 0, 16'h0);
        chk(9'h092, 3'b001);
        rd(uwk_pkg::OFS_CTRL, 32'h0, 32'h2);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
